// ---- verilog/csm_pkg.sv ----
// constants, fields and state types shared by both ends of the port
// assumes a single 25 MHz system clock on both ends
package csm_pkg;

  localparam int DW  = 32;
  localparam int AW  = 10;
  localparam int BEW = 4;
  localparam int HLW = 128;

  // device-side configuration space layout
  localparam int          IDX_ID     = 0;
  localparam int          IDX_STAT   = 1;
  localparam logic [31:0] MASK_LO    = 32'h0000ffff;
  localparam logic [31:0] MASK_HI    = 32'hffff0000;
  localparam logic [31:0] RST_CFG    = 32'h00000000;
  // identity word, value is arbitrary
  localparam logic [31:0] ID_VALUE   = 32'h5a5a0001;
  localparam int          ERR_ACS    = 16;
  localparam int          ERR_COR    = 17;
  localparam int          ERR_ABT    = 18;
  localparam int          ERR_ATM    = 19;

  // controller register map on apb, byte addresses
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_ADDR   = 12'h004;
  localparam logic [11:0] OFS_WDATA  = 12'h008;
  localparam logic [11:0] OFS_RDATA  = 12'h00c;
  localparam logic [11:0] OFS_STAT   = 12'h010;
  localparam logic [11:0] OFS_ERR    = 12'h014;
  localparam int          CTL_START  = 0;
  localparam int          CTL_WRITE  = 1;
  localparam int          CTL_WRO    = 2;
  localparam int          CTL_W1C    = 3;
  localparam int          ADR_BE_LSB = 16;
  localparam int          ST_BUSY    = 0;
  localparam int          ST_DONE    = 1;
  localparam int          ST_QRDY    = 2;
  localparam int          EV_ACS     = 0;
  localparam int          EV_COR     = 1;
  localparam int          EV_ABT     = 2;
  localparam int          EV_ATM     = 3;
  localparam logic [3:0]  RST_BE_N   = 4'h0;

  typedef enum logic [1:0] {
    DEV_IDLE   = 2'b00,
    DEV_ACCESS = 2'b01,
    DEV_DONE   = 2'b11,
    DEV_WAIT   = 2'b10
  } csm_dev_st_t;

  typedef enum logic [1:0] {
    USR_IDLE = 2'b00,
    USR_REQ  = 2'b01,
    USR_END  = 2'b11
  } csm_usr_st_t;

endpackage : csm_pkg

// ---- verilog/csm_if.sv ----
// management and error-report wires between user logic and the device
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface csm_if;
  import csm_pkg::*;
  logic [BEW-1:0] mgmt_byte_sel_n;
  logic [DW-1:0]  mgmt_wr_data;
  logic [DW-1:0]  mgmt_rd_data;
  logic [AW-1:0]  mgmt_dword_addr;
  logic           mgmt_rd_req_n;
  logic           mgmt_wr_req_n;
  logic           mgmt_access_done_n;
  logic           mgmt_write_ro_bits_n;
  logic           mgmt_w1c_as_writable_n;
  logic           err_acs_violation_n;
  logic [HLW-1:0] err_header_log_in;
  logic           err_header_log_set_n;
  logic           err_atomic_blocked_n;
  logic           err_correctable_n;
  logic           err_cpl_abort_n;
  logic           err_cpl_hdr_queue_ready_n;

  modport dev (
    input  mgmt_byte_sel_n, mgmt_wr_data, mgmt_dword_addr, mgmt_rd_req_n,
    input  mgmt_wr_req_n, mgmt_write_ro_bits_n, mgmt_w1c_as_writable_n,
    input  err_acs_violation_n, err_header_log_in, err_atomic_blocked_n,
    input  err_correctable_n, err_cpl_abort_n,
    output mgmt_rd_data, mgmt_access_done_n, err_header_log_set_n,
    output err_cpl_hdr_queue_ready_n
  );

  modport usr (
    output mgmt_byte_sel_n, mgmt_wr_data, mgmt_dword_addr, mgmt_rd_req_n,
    output mgmt_wr_req_n, mgmt_write_ro_bits_n, mgmt_w1c_as_writable_n,
    output err_acs_violation_n, err_header_log_in, err_atomic_blocked_n,
    output err_correctable_n, err_cpl_abort_n,
    input  mgmt_rd_data, mgmt_access_done_n, err_header_log_set_n,
    input  err_cpl_hdr_queue_ready_n
  );
endinterface : csm_if

// ---- verilog/csm_cplq.sv ----
// occupancy tracker of the completion-header queue for error responses
// assumes push is only offered while ready_n_o is low
`timescale 1ns/1ps
module csm_cplq #(
  parameter int DEPTH = 4
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic push_i,
  input  wire logic pop_i,
  output logic      ready_n_o
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  if (DEPTH < 1 || DEPTH > 64)
  begin : g_bad_depth
    $error("csm_cplq: DEPTH out of range");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (push_i && cnt_q != FULL && !(pop_i && cnt_q != '0))
      cnt_d = cnt_q + CW'(1);
    else if (pop_i && cnt_q != '0 && !(push_i && cnt_q != FULL))
      cnt_d = cnt_q - CW'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ready_n_o <= 1'b0;
    else
      ready_n_o <= (cnt_d == FULL);
  end
endmodule : csm_cplq

// ---- verilog/csm_dev.sv ----
// device end: configuration space behind the management port
// assumes user logic on the same clock; atomic report may come unsynced
//
// What this block does
// - active-low byte selects pick bytes of DWORD
// - user drives 32-bit write data into space
// - device returns 32-bit read data
// - user drives 10-bit DWORD address
// - read requested by read request low
// - write requested by write request low
// - done low marks completed access
// - read data valid only while done low
// - write-ro qualifier makes plain RO bits writable, except in the ID word
// - link side still sees those bits read-only
// - w1c qualifier makes w1c bits plain RW
// - otherwise writing one clears w1c bit
// - user reports ACS violation with low pulse
// - header log input held at zero
// - atomic blocked reported low from second domain
// - user reports correctable error low
// - user reports aborted completion low
// - abort ignored while queue ready deasserted
// - queue ready low means header queue has room
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module csm_dev
  import csm_pkg::*;
#(
  parameter int DEPTH  = 16,
  parameter int QDEPTH = 4
) (
  input  wire logic                    CLK_SYS_I,
  input  wire logic                    SYS_RST_I,
  csm_if.dev                           MGMT,
  input  wire logic                    LINK_WR_I,
  input  wire logic [csm_pkg::AW-1:0]  LINK_ADDR_I,
  input  wire logic [csm_pkg::BEW-1:0] LINK_BE_I,
  input  wire logic [csm_pkg::DW-1:0]  LINK_WDATA_I,
  output logic      [csm_pkg::DW-1:0]  LINK_RD_DATA_O,
  input  wire logic                    CPL_HDR_POP_I,
  output logic      [3:0]              ERR_STATUS_O
);
  import csm_pkg::*;

  localparam int IW = $clog2(DEPTH);

  // AW'(DEPTH) in the hit tests must not wrap to zero
  if (DEPTH < 2 || DEPTH > 512 || (1 << IW) != DEPTH)
  begin : g_bad_depth
    $error("csm_dev: DEPTH must be a power of two, 2 to 512");
  end

  function automatic logic [31:0] rw_mask(input logic [IW-1:0] idx);
    rw_mask = (int'(idx) == IDX_ID) ? '0 : MASK_LO;
  endfunction : rw_mask

  function automatic logic [31:0] ro_mask(input logic [IW-1:0] idx);
    ro_mask = (int'(idx) == IDX_ID || int'(idx) == IDX_STAT) ? '0 : MASK_HI;
  endfunction : ro_mask

  function automatic logic [31:0] w1c_mask(input logic [IW-1:0] idx);
    w1c_mask = (int'(idx) == IDX_STAT) ? MASK_HI : '0;
  endfunction : w1c_mask

  function automatic logic [31:0] lanes(input logic [3:0] sel);
    lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lanes

  // one write merged into an old word; link writes never get qualifiers
  function automatic logic [31:0] merge(
    input logic [31:0]   old,
    input logic [31:0]   data,
    input logic [3:0]    sel,
    input logic [IW-1:0] idx,
    input logic          wro,
    input logic          w1c_rw,
    input logic          link
  );
    logic [31:0] en;
    logic [31:0] wr;
    logic [31:0] res;
    en = lanes(sel);
    wr = rw_mask(idx);
    if (!link && wro)
      wr = wr | ro_mask(idx);
    if (!link && w1c_rw)
      wr = wr | w1c_mask(idx);
    res = (old & ~(wr & en)) | (data & wr & en);
    if (link || !w1c_rw)
      res = res & ~(w1c_mask(idx) & en & data);
    merge = res;
  endfunction : merge

  csm_dev_st_t   st_q;
  logic [DW-1:0] cfg_q [DEPTH];
  logic [DW-1:0] cfg_d [DEPTH];
  logic [DW-1:0] rd_data_q;
  logic          done_n_q;
  logic          log_set_n_q;
  logic [DW-1:0] link_rd_q;
  logic [3:0]    err_q;
  logic [2:0]    atm_sync_q;
  logic          atm_lvl_q;
  logic          qrdy_n;
  logic          abort_ok;
  logic          rd_req;
  logic          wr_req;
  logic          user_hit;
  logic          user_wr;
  logic [IW-1:0] user_idx;
  logic [IW-1:0] link_idx;
  logic [3:0]    ev;

  assign rd_req   = !MGMT.mgmt_rd_req_n;
  assign wr_req   = !MGMT.mgmt_wr_req_n;
  assign user_idx = MGMT.mgmt_dword_addr[IW-1:0];
  assign link_idx = LINK_ADDR_I[IW-1:0];
  assign user_hit = (MGMT.mgmt_dword_addr < AW'(DEPTH));
  assign user_wr  = (st_q == DEV_ACCESS) && wr_req && !rd_req && user_hit;
  assign abort_ok = !MGMT.err_cpl_abort_n && !qrdy_n;

  assign ev[EV_ACS] = !MGMT.err_acs_violation_n;
  assign ev[EV_COR] = !MGMT.err_correctable_n;
  assign ev[EV_ABT] = abort_ok;
  assign ev[EV_ATM] = !atm_lvl_q;

  csm_cplq #(
    .DEPTH     (QDEPTH)
  ) u_cplq (
    .clk_i     (CLK_SYS_I),
    .rst_i     (SYS_RST_I),
    .push_i    (abort_ok),
    .pop_i     (CPL_HDR_POP_I),
    .ready_n_o (qrdy_n)
  );

  // atomic report treated as foreign: three stages, act when 2 and 3 agree
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      atm_sync_q <= 3'h7;
      atm_lvl_q  <= 1'b1;
    end
    else
    begin
      atm_sync_q <= {atm_sync_q[1:0], MGMT.err_atomic_blocked_n};
      if (atm_sync_q[1] == atm_sync_q[2])
        atm_lvl_q <= atm_sync_q[2];
    end
  end

  // user write first, link write over it, error sets win over clears
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
      cfg_d[i] = cfg_q[i];
    if (user_wr)
      cfg_d[user_idx] = merge(cfg_q[user_idx], MGMT.mgmt_wr_data,
                              ~MGMT.mgmt_byte_sel_n, user_idx,
                              !MGMT.mgmt_write_ro_bits_n,
                              !MGMT.mgmt_w1c_as_writable_n, 1'b0);
    if (LINK_WR_I && LINK_ADDR_I < AW'(DEPTH))
      cfg_d[link_idx] = merge(cfg_d[link_idx], LINK_WDATA_I, LINK_BE_I,
                              link_idx, 1'b0, 1'b0, 1'b1);
    cfg_d[IDX_STAT][ERR_ATM:ERR_ACS] = cfg_d[IDX_STAT][ERR_ATM:ERR_ACS] | ev;
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      for (int i = 0; i < DEPTH; i++)
        cfg_q[i] <= (i == IDX_ID) ? ID_VALUE : RST_CFG;
    end
    else
    begin
      for (int i = 0; i < DEPTH; i++)
        cfg_q[i] <= cfg_d[i];
    end
  end

  // access sequencer
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      st_q      <= DEV_IDLE;
      done_n_q  <= 1'b1;
      rd_data_q <= '0;
    end
    else
    begin
      case (st_q)
        DEV_IDLE:
        begin
          if (rd_req != wr_req)
            st_q <= DEV_ACCESS;
        end
        DEV_ACCESS:
        begin
          st_q     <= DEV_DONE;
          done_n_q <= 1'b0;
          if (rd_req && user_hit)
            rd_data_q <= cfg_q[user_idx];
          else
            rd_data_q <= '0;
        end
        DEV_DONE:
        begin
          st_q      <= DEV_WAIT;
          done_n_q  <= 1'b1;
          rd_data_q <= '0;
        end
        DEV_WAIT:
        begin
          if (!rd_req && !wr_req)
            st_q <= DEV_IDLE;
        end
        default:
        begin
          st_q     <= DEV_IDLE;
          done_n_q <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      link_rd_q   <= '0;
      err_q       <= '0;
      log_set_n_q <= 1'b1;
    end
    else
    begin
      link_rd_q   <= (LINK_ADDR_I < AW'(DEPTH)) ? cfg_q[link_idx] : '0;
      err_q       <= cfg_q[IDX_STAT][ERR_ATM:ERR_ACS];
      log_set_n_q <= 1'b1;
    end
  end

  assign MGMT.mgmt_rd_data              = rd_data_q;
  assign MGMT.mgmt_access_done_n        = done_n_q;
  assign MGMT.err_header_log_set_n      = log_set_n_q;
  assign MGMT.err_cpl_hdr_queue_ready_n = qrdy_n;
  assign LINK_RD_DATA_O                 = link_rd_q;
  assign ERR_STATUS_O                   = err_q;
endmodule : csm_dev

// ---- verilog/csm_usr.sv ----
// user end: apb-programmed controller driving the management port
// assumes the device answers on the same clock; no timeout of its own
`timescale 1ns/1ps
module csm_usr
  import csm_pkg::*;
(
  input  wire logic          CLK_SYS_I,
  input  wire logic          SYS_RST_I,
  input  wire logic          PSEL_I,
  input  wire logic          PENABLE_I,
  input  wire logic          PWRITE_I,
  input  wire logic [11:0]   PADDR_I,
  input  wire logic [31:0]   PWDATA_I,
  output logic      [31:0]   PRDATA_O,
  output logic               PREADY_O,
  output logic               PSLVERR_O,
  csm_if.usr                 MGMT
);
  import csm_pkg::*;

  csm_usr_st_t    st_q;
  logic [3:0]     ctrl_q;
  logic [AW-1:0]  addr_q;
  logic [BEW-1:0] be_n_q;
  logic [DW-1:0]  wdata_q;
  logic [DW-1:0]  rdata_q;
  logic           done_q;
  logic           rd_n_q;
  logic           wr_n_q;
  logic [3:0]     ev_n_q;
  logic           atm_more_q;
  logic [31:0]    prdata_q;
  logic           pready_q;
  logic           pslverr_q;
  logic           setup;
  logic           wr_acc;
  logic           mapped;
  logic           start;
  logic           busy;

  assign setup  = PSEL_I && !PENABLE_I;
  assign wr_acc = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && !PSLVERR_O;
  assign mapped = (PADDR_I <= OFS_ERR) && (PADDR_I[1:0] == 2'b00);
  assign busy   = (st_q != USR_IDLE);
  assign start  = wr_acc && PADDR_I == OFS_CTRL && PWDATA_I[CTL_START]
                  && !busy;

  // apb slave: answer prepared in setup, ready in first access cycle
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end
    else
    begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped;
      prdata_q  <= '0;
      if (setup && !PWRITE_I)
      begin
        case (PADDR_I)
          OFS_CTRL:  prdata_q <= {28'h0, ctrl_q};
          OFS_ADDR:  prdata_q <= {12'h0, be_n_q, 6'h0, addr_q};
          OFS_WDATA: prdata_q <= wdata_q;
          OFS_RDATA: prdata_q <= rdata_q;
          OFS_STAT:  prdata_q <= {29'h0, !MGMT.err_cpl_hdr_queue_ready_n,
                                  done_q, busy};
          default:   prdata_q <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      ctrl_q  <= '0;
      addr_q  <= '0;
      be_n_q  <= RST_BE_N;
      wdata_q <= '0;
    end
    else if (wr_acc && !busy)
    begin
      if (PADDR_I == OFS_CTRL)
        ctrl_q <= {PWDATA_I[CTL_W1C:CTL_WRITE], 1'b0};
      if (PADDR_I == OFS_ADDR)
      begin
        addr_q <= PWDATA_I[AW-1:0];
        be_n_q <= PWDATA_I[ADR_BE_LSB+BEW-1:ADR_BE_LSB];
      end
      if (PADDR_I == OFS_WDATA)
        wdata_q <= PWDATA_I;
    end
  end

  // one-cycle low error reports; atomic held two cycles so that the
  // far-end three-stage filter sees stages two and three agree
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      ev_n_q     <= 4'hf;
      atm_more_q <= 1'b0;
    end
    else if (wr_acc && PADDR_I == OFS_ERR)
    begin
      ev_n_q     <= ~PWDATA_I[EV_ATM:EV_ACS];
      atm_more_q <= PWDATA_I[EV_ATM];
    end
    else
    begin
      ev_n_q     <= {!atm_more_q, 3'h7};
      atm_more_q <= 1'b0;
    end
  end

  // request held until done seen, then released
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      st_q    <= USR_IDLE;
      rd_n_q  <= 1'b1;
      wr_n_q  <= 1'b1;
      done_q  <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      case (st_q)
        USR_IDLE:
        begin
          if (wr_acc && PADDR_I == OFS_STAT && PWDATA_I[ST_DONE])
            done_q <= 1'b0;
          if (start)
          begin
            st_q   <= USR_REQ;
            done_q <= 1'b0;
            rd_n_q <= PWDATA_I[CTL_WRITE];
            wr_n_q <= !PWDATA_I[CTL_WRITE];
          end
        end
        USR_REQ:
        begin
          if (!MGMT.mgmt_access_done_n)
          begin
            st_q   <= USR_END;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            if (!rd_n_q)
              rdata_q <= MGMT.mgmt_rd_data;
          end
        end
        USR_END:
        begin
          st_q   <= USR_IDLE;
          done_q <= 1'b1;
        end
        default:
        begin
          st_q   <= USR_IDLE;
          rd_n_q <= 1'b1;
          wr_n_q <= 1'b1;
        end
      endcase
    end
  end

  assign PRDATA_O  = prdata_q;
  assign PREADY_O  = pready_q;
  assign PSLVERR_O = pslverr_q;

  assign MGMT.mgmt_rd_req_n          = rd_n_q;
  assign MGMT.mgmt_wr_req_n          = wr_n_q;
  assign MGMT.mgmt_dword_addr        = addr_q;
  assign MGMT.mgmt_byte_sel_n        = be_n_q;
  assign MGMT.mgmt_wr_data           = wdata_q;
  assign MGMT.mgmt_write_ro_bits_n   = !ctrl_q[CTL_WRO];
  assign MGMT.mgmt_w1c_as_writable_n = !ctrl_q[CTL_W1C];
  assign MGMT.err_header_log_in      = '0;
  assign MGMT.err_acs_violation_n    = ev_n_q[EV_ACS];
  assign MGMT.err_correctable_n      = ev_n_q[EV_COR];
  assign MGMT.err_cpl_abort_n        = ev_n_q[EV_ABT];
  assign MGMT.err_atomic_blocked_n   = ev_n_q[EV_ATM];
endmodule : csm_usr

// ---- dv/csm_assertions.sv ----
// checker: timing and value relations on the management port wires
// assumes both ends share CLK_SYS_I and the sync active-high reset
`timescale 1ns/1ps
module csm_assertions (
  input  wire logic         CLK_SYS_I,
  input  wire logic         SYS_RST_I,
  input  wire logic         mgmt_rd_req_n,
  input  wire logic         mgmt_wr_req_n,
  input  wire logic         mgmt_access_done_n,
  input  wire logic [31:0]  mgmt_rd_data,
  input  wire logic [9:0]   mgmt_dword_addr,
  input  wire logic [31:0]  mgmt_wr_data,
  input  wire logic [3:0]   mgmt_byte_sel_n,
  input  wire logic [127:0] err_header_log_in,
  input  wire logic         err_acs_violation_n,
  input  wire logic         err_correctable_n,
  input  wire logic         err_cpl_abort_n,
  input  wire logic         err_cpl_hdr_queue_ready_n
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (SYS_RST_I);

  a_done_single: assert property (
    !mgmt_access_done_n |=> mgmt_access_done_n [*2])
    else $error("done not a lone one-cycle pulse");
  a_rd_answer: assert property (
    $fell(mgmt_rd_req_n) |-> ##[1:3] !mgmt_access_done_n)
    else $error("read not completed in time");
  a_wr_answer: assert property (
    $fell(mgmt_wr_req_n) |-> ##[1:3] !mgmt_access_done_n)
    else $error("write not completed in time");
  a_rd_data_idle: assert property (
    mgmt_access_done_n |-> mgmt_rd_data == 32'h00000000)
    else $error("read data shown outside done");
  a_req_single: assert property (
    mgmt_rd_req_n || mgmt_wr_req_n)
    else $error("read and write requested together");
  a_req_held: assert property (
    ($fell(mgmt_rd_req_n) || $fell(mgmt_wr_req_n)) |=>
      ($stable(mgmt_rd_req_n) && $stable(mgmt_wr_req_n) &&
       $stable(mgmt_dword_addr) && $stable(mgmt_wr_data) &&
       $stable(mgmt_byte_sel_n)) until !mgmt_access_done_n)
    else $error("request changed before done");
  a_log_zero: assert property (
    err_header_log_in == 128'h0)
    else $error("header log input not zero");
  a_acs_pulse: assert property (
    !err_acs_violation_n |=> err_acs_violation_n)
    else $error("acs report longer than one cycle");
  a_cor_pulse: assert property (
    !err_correctable_n |=> err_correctable_n)
    else $error("correctable report longer than one cycle");
  a_queue_full: assert property (
    $rose(err_cpl_hdr_queue_ready_n) |->
      (!$past(err_cpl_abort_n) || !$past(err_cpl_abort_n, 2)))
    else $error("queue went full without an abort");
endmodule : csm_assertions

// ---- dv/csm_bench.sv ----
// bench: both ends joined by the interface, driven over apb
// assumes one 25 MHz clock and a sync active-high reset
`timescale 1ns/1ps
module csm_bench;
  import csm_pkg::*;
  logic        clk, rst, psel, pen, pwr, lwr, pop, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lwd, lrd, r;
  logic [9:0]  ladr;
  logic [3:0]  lbe, est;
  int          n_fail = 0;
  int          check_count = 0;
  int          cyc = 0;

  csm_if mgmt_if ();
  csm_usr csm_usr_inst (.CLK_SYS_I(clk), .SYS_RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .MGMT(mgmt_if.usr));
  csm_dev #(.DEPTH(16), .QDEPTH(4)) csm_dev_inst (.CLK_SYS_I(clk),
    .SYS_RST_I(rst), .MGMT(mgmt_if.dev), .LINK_WR_I(lwr),
    .LINK_ADDR_I(ladr), .LINK_BE_I(lbe), .LINK_WDATA_I(lwd),
    .LINK_RD_DATA_O(lrd), .CPL_HDR_POP_I(pop), .ERR_STATUS_O(est));
  csm_assertions csm_assertions_inst (.CLK_SYS_I(clk), .SYS_RST_I(rst),
    .mgmt_rd_req_n(mgmt_if.mgmt_rd_req_n),
    .mgmt_wr_req_n(mgmt_if.mgmt_wr_req_n),
    .mgmt_access_done_n(mgmt_if.mgmt_access_done_n),
    .mgmt_rd_data(mgmt_if.mgmt_rd_data),
    .mgmt_dword_addr(mgmt_if.mgmt_dword_addr),
    .mgmt_wr_data(mgmt_if.mgmt_wr_data),
    .mgmt_byte_sel_n(mgmt_if.mgmt_byte_sel_n),
    .err_header_log_in(mgmt_if.err_header_log_in),
    .err_acs_violation_n(mgmt_if.err_acs_violation_n),
    .err_correctable_n(mgmt_if.err_correctable_n),
    .err_cpl_abort_n(mgmt_if.err_cpl_abort_n),
    .err_cpl_hdr_queue_ready_n(mgmt_if.err_cpl_hdr_queue_ready_n));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task report_and_stop;
    if (n_fail == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // hang guard, far above the length of the sequence
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      report_and_stop;
    end
  end

  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask : chk

  // request held to the edge at which pready is seen, answer taken there
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  // q: {w1c_as_rw, write_ro, write}
  task mop(input logic [2:0] q, input logic [9:0] a, input logic [3:0] b,
           input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    apb(1'b1, OFS_ADDR, {12'h000, b, 6'h00, a}, rd, e);
    apb(1'b1, OFS_WDATA, d, rd, e);
    apb(1'b1, OFS_CTRL, {28'h0000000, q, 1'b1}, rd, e);
    do
    begin
      apb(1'b0, OFS_STAT, 32'h00000000, rd, e);
      n++;
    end
    while (rd[ST_DONE] !== 1'b1 && n < 40);
    chk("done", 32'h00000001, {31'h0, rd[ST_DONE]});
    apb(1'b0, OFS_RDATA, 32'h00000000, rd, e);
  endtask : mop

  task wrd(input logic [2:0] q, input logic [9:0] a, input logic [3:0] b,
           input logic [31:0] d, input logic [31:0] x, input string nm);
    mop(q, a, b, d, r);
    mop(3'b000, a, 4'h0, 32'h00000000, r);
    chk(nm, x, r);
  endtask : wrd

  task errp(input logic [3:0] v);
    apb(1'b1, OFS_ERR, {28'h0000000, v}, r, e);
    repeat (8) @(posedge clk);
  endtask : errp

  task lnk(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    lwr  <= w;
    ladr <= a;
    lbe  <= 4'hf;
    lwd  <= d;
    @(posedge clk);
    lwr <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask : lnk

  initial
  begin
    rst = 1'b1;
    {psel, pen, pwr, lwr, pop, paddr, pwdata, ladr, lbe, lwd} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, OFS_STAT, 32'h00000000, r, e);
    chk("qrdy_rst", 32'h00000001, {31'h0, r[ST_QRDY]});
    wrd(3'b000, 10'h000, 4'h0, 32'h0, ID_VALUE, "id");
    wrd(3'b001, 10'h002, 4'h0, 32'hffffffff, 32'h0000ffff, "ro");
    wrd(3'b011, 10'h002, 4'h0, 32'habcd1234, 32'habcd1234, "wro");
    wrd(3'b011, 10'h000, 4'h0, 32'hffffffff, ID_VALUE, "fix");
    lnk(1'b1, 10'h002, 32'h00000000);
    lnk(1'b0, 10'h002, 32'h00000000);
    chk("link_ro", 32'habcd0000, lrd);
    wrd(3'b011, 10'h003, 4'h5, 32'h11223344, 32'h11003300, "be");
    errp(4'h3);
    chk("acs_cor", 32'h00000003, {28'h0, est});
    wrd(3'b000, 10'h001, 4'h0, 32'h0, 32'h00030000, "st");
    wrd(3'b001, 10'h001, 4'h0, 32'h00010000, 32'h00020000, "clr");
    wrd(3'b101, 10'h001, 4'h0, 32'h00080000, 32'h00080000, "rw");
    wrd(3'b001, 10'h001, 4'h0, 32'hffff0000, 32'h0, "clr_all");
    errp(4'h8);
    chk("atomic", 32'h00000008, {28'h0, est});
    wrd(3'b001, 10'h001, 4'h0, 32'hffff0000, 32'h0, "clr_atm");
    repeat (4) errp(4'h4);
    chk("abort", 32'h00000004, {28'h0, est});
    apb(1'b0, OFS_STAT, 32'h00000000, r, e);
    chk("q_full", 32'h00000000, {31'h0, r[ST_QRDY]});
    wrd(3'b001, 10'h001, 4'h0, 32'h00040000, 32'h0, "clr_abt");
    errp(4'h4);
    chk("abt_ign", 32'h00000000, {28'h0, est});
    @(posedge clk);
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, OFS_STAT, 32'h00000000, r, e);
    chk("q_room", 32'h00000001, {31'h0, r[ST_QRDY]});
    errp(4'h4);
    chk("abt_ok", 32'h00000004, {28'h0, est});
    wrd(3'b001, 10'h3ff, 4'h0, 32'h12345678, 32'h0, "unmapped");
    apb(1'b0, 12'h018, 32'h00000000, r, e);
    chk("slverr", 32'h00000001, {31'h0, e});
    report_and_stop;
  end
endmodule : csm_bench
